/* File: common/exc_pkg.sv */
// shared constants and types of the exception prioritiser
package exc_pkg;

	// ==========================================================
	// exception kinds, index 0 is the most urgent
	localparam int EXC_N = 13;
	localparam int EXC_IDX_W = 4;
	localparam logic [3:0] EX_HRST = 4'h0;
	localparam logic [3:0] EX_SRST = 4'h1;
	localparam logic [3:0] EX_DSS = 4'h2;
	localparam logic [3:0] EX_DEBUG_INTERRUPT_EVENT = 4'h3;
	localparam logic [3:0] EX_NMI = 4'h4;
	localparam logic [3:0] EX_INT = 4'h5;
	localparam logic [3:0] EX_DIB = 4'h6;
	localparam logic [3:0] EX_DDB = 4'h7;
	localparam logic [3:0] EX_LOAD_MISALIGN_ERROR = 4'h8;
	localparam logic [3:0] EX_IBE = 4'h9;
	localparam logic [3:0] EX_DBP = 4'hA;
	localparam logic [3:0] EX_SYS = 4'hB;
	localparam logic [3:0] EX_BP = 4'hC;

	// ==========================================================
	// vectors and cause codes
	localparam logic [31:0] VEC_BOOT = 32'hBFC0_0000;
	localparam logic [31:0] VEC_DBG_NOPROBE = 32'hBFC0_0480;
	localparam logic [31:0] VEC_DBG_PROBE = 32'hBFC0_0200;
	localparam logic [31:0] GEN_OFFSET = 32'h0000_0180;
	localparam logic [31:0] INT_OFFSET = 32'h0000_0200;
	localparam logic [31:0] EXC_BASE_RST = 32'h8000_0000;
	localparam logic [31:0] EXC_BASE_MASK = 32'hFFFF_F000;
	localparam logic [4:0] CAUSE_INT = 5'h00;
	localparam logic [4:0] CAUSE_LOAD_MISALIGN_ERROR = 5'h04;
	localparam logic [4:0] CAUSE_IBE = 5'h06;
	localparam logic [4:0] CAUSE_SYS = 5'h08;
	localparam logic [4:0] CAUSE_BP = 5'h09;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_BASE = 8'h04;
	localparam logic [7:0] OFF_FLAGS = 8'h08;
	localparam logic [7:0] OFF_VECTOR = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
	localparam logic [3:0] PAGE_IBRK = 4'h2;
	localparam logic [3:0] PAGE_DBRK = 4'h3;
	localparam int NUM_IBRK = 4;
	localparam int NUM_DBRK = 2;
	localparam int BRK_IDX_W = 2;
	localparam int FLAG_BITS = 10;
	localparam int IPL_LSB = 10;

	// ==========================================================
	// types
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_state_t;

	typedef struct packed {
		logic int_enable;
		logic debug_break_request;
		logic probe_enable;
	} ctrl_t;

	typedef struct packed {
		logic [4:0] cause_code;
		logic [2:0] interrupt_priority_level;
		logic data_break_event;
		logic software_breakpoint_event;
		logic instruction_break_event;
		logic debug_interrupt_event;
		logic single_step_debug;
		logic exception_level_flag;
		logic nonmaskable_flag;
		logic soft_reset_flag;
		logic error_level_flag;
		logic boot_vector_select;
	} proc_flags_t;

	localparam proc_flags_t FLAGS_RST = 18'h00003;

	typedef struct packed {
		logic soft_reset_instr;
		logic single_step;
		logic nmi;
		logic int_req;
		logic [2:0] int_level;
		logic load_misalign_error;
		logic fetch_bus_error;
		logic debug_breakpoint_instruction;
		logic syscall_instr;
		logic break_instr;
		logic fetch_valid;
		logic [31:0] fetch_addr;
		logic data_valid;
		logic [31:0] data_addr;
	} exc_src_t;

	typedef struct packed {
		logic take;
		logic [3:0] kind;
		logic [31:0] vector;
	} exc_out_t;

endpackage

/* File: core/brk_matcher.sv */
// bank of address breakpoints with a bus write and read port
`timescale 1ns/100ps
`default_nettype none
module brk_matcher #(
	parameter int N = 4,
	parameter int IDXW = 2
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic wr_en,
	input wire logic [IDXW-1:0] wr_idx,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] wr_be,
	input wire logic [IDXW-1:0] rd_idx,
	output logic [31:0] rd_data,
	input wire logic probe_valid,
	input wire logic [31:0] probe_addr,
	output logic hit
);
	if (N < 1 || N > (1 << IDXW)) begin : g_check
		$error("brk_matcher: N does not fit IDXW");
	end

	// bit 0 of each slot enables it; bits 31:1 hold the address
	logic [N-1:0][31:0] slot;
	logic [N-1:0][31:0] next_slot;
	logic [N-1:0] match;
	logic [31:0] mask;

	assign mask = {{8{wr_be[3]}}, {8{wr_be[2]}},
		{8{wr_be[1]}}, {8{wr_be[0]}}};

	genvar i;
	for (i = 0; i < N; i++) begin : g_slot
		assign match[i] = slot[i][0] && probe_valid &&
			(slot[i][31:1] == probe_addr[31:1]);
	end

	assign hit = |match;
	assign rd_data = slot[rd_idx];

	always_comb begin
		next_slot = slot;
		if (wr_en) begin
			next_slot[wr_idx] = (slot[wr_idx] & ~mask) |
				(wr_data & mask);
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			slot <= '0;
		end else begin
			slot <= next_slot;
		end
	end
endmodule
`default_nettype wire

/* File: core/cpu_exception_prioritizer.sv */
// exception prioritiser: ranking, vectors, flags, register slave
//
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module cpu_exception_prioritizer #(
	parameter int IBRK_N = exc_pkg::NUM_IBRK,
	parameter int DBRK_N = exc_pkg::NUM_DBRK
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic master_clear_pin_n,
	input wire logic probe_break,
	input wire exc_pkg::exc_src_t src,
	output exc_pkg::exc_out_t exc,
	output exc_pkg::proc_flags_t flags,
	output logic irq
);
	if (IBRK_N < 1 || IBRK_N > 4 || DBRK_N < 1 || DBRK_N > 4)
	begin : g_check
		$error("breakpoint counts must lie in 1..4");
	end

	// ==========================================================
	// state
	localparam int CW = $bits(exc_pkg::ctrl_t);
	localparam int FW = $bits(exc_pkg::proc_flags_t);
	localparam logic [FW-1:0] FLAG_W1C = FW'((1 << exc_pkg::FLAG_BITS) - 1);

	typedef struct packed {
		exc_pkg::bus_state_t bus;
		logic [31:0] rdata;
		exc_pkg::ctrl_t ctrl;
		logic [31:0] exc_base;
		exc_pkg::proc_flags_t flags;
		logic [exc_pkg::EXC_N-1:0] irq_status;
		logic [exc_pkg::EXC_N-1:0] irq_mask;
		exc_pkg::exc_out_t exc;
		logic [2:0] master_clear_pin_sync;
	} state_t;

	state_t st;
	state_t next_st;

	logic req;
	logic acked;
	logic [7:0] word_off;
	logic [3:0] page;
	logic [31:0] wmask;
	logic [31:0] wbits;
	logic ibrk_wr;
	logic dbrk_wr;
	logic [31:0] ibrk_rd;
	logic [31:0] dbrk_rd;
	logic ibrk_hit;
	logic dbrk_hit;
	logic master_clear_pin_assert;
	logic int_ok;
	logic [exc_pkg::EXC_N-1:0] pend;
	logic pick_valid;
	logic [exc_pkg::EXC_IDX_W-1:0] pick;
	logic [31:0] dbg_vec;
	logic [31:0] gen_vec;
	logic [31:0] rd_mux;

	// ==========================================================
	// bus decode
	assign req = avs_read || avs_write;
	assign acked = (st.bus == exc_pkg::BUS_ACK);
	assign avs_waitrequest = req && !acked;
	assign avs_readdata = st.rdata;
	assign word_off = {avs_address[7:2], 2'b00};
	assign page = avs_address[7:4];
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign wbits = avs_writedata & wmask;
	assign ibrk_wr = avs_write && acked &&
		(page == exc_pkg::PAGE_IBRK) &&
		(32'(avs_address[3:2]) < IBRK_N);
	assign dbrk_wr = avs_write && acked &&
		(page == exc_pkg::PAGE_DBRK) &&
		(32'(avs_address[3:2]) < DBRK_N);

	always_comb begin
		rd_mux = '0;
		case (word_off)
		exc_pkg::OFF_CTRL: rd_mux = 32'(st.ctrl);
		exc_pkg::OFF_BASE: rd_mux = st.exc_base;
		exc_pkg::OFF_FLAGS: rd_mux = 32'(st.flags);
		exc_pkg::OFF_VECTOR: rd_mux = st.exc.vector;
		exc_pkg::OFF_IRQ_STATUS: rd_mux = 32'(st.irq_status);
		exc_pkg::OFF_IRQ_MASK: rd_mux = 32'(st.irq_mask);
		default: begin
			if (page == exc_pkg::PAGE_IBRK &&
				32'(avs_address[3:2]) < IBRK_N) begin
				rd_mux = ibrk_rd;
			end else if (page == exc_pkg::PAGE_DBRK &&
				32'(avs_address[3:2]) < DBRK_N) begin
				rd_mux = dbrk_rd;
			end
		end
		endcase
	end

	// ==========================================================
	// breakpoints
	brk_matcher #(
		.N(IBRK_N),
		.IDXW(exc_pkg::BRK_IDX_W)
	) u_ibrk (
		.clk(clk),
		.srst(srst),
		.wr_en(ibrk_wr),
		.wr_idx(avs_address[3:2]),
		.wr_data(avs_writedata),
		.wr_be(avs_byteenable),
		.rd_idx(avs_address[3:2]),
		.rd_data(ibrk_rd),
		.probe_valid(src.fetch_valid),
		.probe_addr(src.fetch_addr),
		.hit(ibrk_hit)
	);

	brk_matcher #(
		.N(DBRK_N),
		.IDXW(exc_pkg::BRK_IDX_W)
	) u_dbrk (
		.clk(clk),
		.srst(srst),
		.wr_en(dbrk_wr),
		.wr_idx(avs_address[3:2]),
		.wr_data(avs_writedata),
		.wr_be(avs_byteenable),
		.rd_idx(avs_address[3:2]),
		.rd_data(dbrk_rd),
		.probe_valid(src.data_valid),
		.probe_addr(src.data_addr),
		.hit(dbrk_hit)
	);

	// ==========================================================
	// pending sources and ranking
	// bit 2 is the previous synchronised level, bit 1 the current
	assign master_clear_pin_assert = st.master_clear_pin_sync[2] && !st.master_clear_pin_sync[1];
	assign int_ok = src.int_req && st.ctrl.int_enable &&
		!st.flags.exception_level_flag &&
		!st.flags.error_level_flag &&
		(src.int_level > st.flags.interrupt_priority_level);

	always_comb begin
		pend = '0;
		pend[exc_pkg::EX_HRST] = master_clear_pin_assert;
		pend[exc_pkg::EX_SRST] = src.soft_reset_instr;
		pend[exc_pkg::EX_DSS] = src.single_step;
		pend[exc_pkg::EX_DEBUG_INTERRUPT_EVENT] = st.ctrl.debug_break_request;
		pend[exc_pkg::EX_NMI] = src.nmi;
		pend[exc_pkg::EX_INT] = int_ok;
		pend[exc_pkg::EX_DIB] = ibrk_hit;
		pend[exc_pkg::EX_DDB] = dbrk_hit;
		pend[exc_pkg::EX_LOAD_MISALIGN_ERROR] = src.load_misalign_error;
		pend[exc_pkg::EX_IBE] = src.fetch_bus_error;
		pend[exc_pkg::EX_DBP] = src.debug_breakpoint_instruction;
		pend[exc_pkg::EX_SYS] = src.syscall_instr;
		pend[exc_pkg::EX_BP] = src.break_instr;
	end

	exc_priority #(
		.N(exc_pkg::EXC_N),
		.W(exc_pkg::EXC_IDX_W)
	) u_prio (
		.req(pend),
		.valid(pick_valid),
		.idx(pick)
	);

	assign dbg_vec = st.ctrl.probe_enable ? exc_pkg::VEC_DBG_PROBE :
		exc_pkg::VEC_DBG_NOPROBE;
	assign gen_vec = st.exc_base + exc_pkg::GEN_OFFSET;

	// ==========================================================
	// next state
	always_comb begin
		next_st = st;
		next_st.exc.take = 1'b0;
		next_st.master_clear_pin_sync = {st.master_clear_pin_sync[1:0], master_clear_pin_n};

		// bus slave, writes land on the acknowledging edge
		case (st.bus)
		exc_pkg::BUS_IDLE: begin
			if (req) begin
				next_st.bus = exc_pkg::BUS_ACK;
				next_st.rdata = avs_read ? rd_mux : 32'h0000_0000;
			end
		end
		exc_pkg::BUS_ACK: begin
			next_st.bus = exc_pkg::BUS_IDLE;
			if (avs_write) begin
				case (word_off)
				exc_pkg::OFF_CTRL: begin
					next_st.ctrl = (st.ctrl & ~wmask[CW-1:0]) |
						wbits[CW-1:0];
				end
				exc_pkg::OFF_BASE: begin
					next_st.exc_base = ((st.exc_base & ~wmask) |
						wbits) & exc_pkg::EXC_BASE_MASK;
				end
				exc_pkg::OFF_FLAGS: begin
					next_st.flags = st.flags &
						~(wbits[FW-1:0] & FLAG_W1C);
					if (avs_byteenable[1]) begin
						next_st.flags.interrupt_priority_level =
							avs_writedata[exc_pkg::IPL_LSB +: 3];
					end
				end
				exc_pkg::OFF_IRQ_STATUS: begin
					next_st.irq_status = st.irq_status &
						~wbits[exc_pkg::EXC_N-1:0];
				end
				exc_pkg::OFF_IRQ_MASK: begin
					next_st.irq_mask = (st.irq_mask &
						~wmask[exc_pkg::EXC_N-1:0]) |
						wbits[exc_pkg::EXC_N-1:0];
				end
				default: begin
				end
				endcase
			end
		end
		default: next_st.bus = exc_pkg::BUS_IDLE;
		endcase

		// exception taken this cycle; hardware sets win over clears
		if (pick_valid) begin
			next_st.exc.take = 1'b1;
			next_st.exc.kind = pick;
			next_st.irq_status[pick] = 1'b1;
			case (pick)
			exc_pkg::EX_HRST: begin
				next_st.exc.vector = exc_pkg::VEC_BOOT;
				next_st.flags.boot_vector_select = 1'b1;
				next_st.flags.error_level_flag = 1'b1;
				next_st.flags.soft_reset_flag = 1'b0;
				next_st.flags.nonmaskable_flag = 1'b0;
			end
			exc_pkg::EX_SRST: begin
				next_st.exc.vector = exc_pkg::VEC_BOOT;
				next_st.flags.boot_vector_select = 1'b1;
				next_st.flags.soft_reset_flag = 1'b1;
				next_st.flags.error_level_flag = 1'b1;
			end
			exc_pkg::EX_DSS: begin
				next_st.exc.vector = dbg_vec;
				next_st.flags.single_step_debug = 1'b1;
			end
			exc_pkg::EX_DEBUG_INTERRUPT_EVENT: begin
				next_st.exc.vector = dbg_vec;
				next_st.flags.debug_interrupt_event = 1'b1;
				next_st.ctrl.debug_break_request = 1'b0;
			end
			exc_pkg::EX_NMI: begin
				next_st.exc.vector = exc_pkg::VEC_BOOT;
				next_st.flags.boot_vector_select = 1'b1;
				next_st.flags.nonmaskable_flag = 1'b1;
				next_st.flags.error_level_flag = 1'b1;
			end
			exc_pkg::EX_INT: begin
				next_st.exc.vector = st.exc_base + exc_pkg::INT_OFFSET;
				next_st.flags.cause_code = exc_pkg::CAUSE_INT;
				next_st.flags.interrupt_priority_level =
					src.int_level;
			end
			exc_pkg::EX_DIB: begin
				next_st.exc.vector = dbg_vec;
				next_st.flags.instruction_break_event = 1'b1;
			end
			exc_pkg::EX_DDB: begin
				next_st.exc.vector = dbg_vec;
				next_st.flags.data_break_event = 1'b1;
			end
			exc_pkg::EX_LOAD_MISALIGN_ERROR: begin
				next_st.exc.vector = gen_vec;
				next_st.flags.exception_level_flag = 1'b1;
				next_st.flags.cause_code = exc_pkg::CAUSE_LOAD_MISALIGN_ERROR;
			end
			exc_pkg::EX_IBE: begin
				next_st.exc.vector = gen_vec;
				next_st.flags.exception_level_flag = 1'b1;
				next_st.flags.cause_code = exc_pkg::CAUSE_IBE;
			end
			exc_pkg::EX_DBP: begin
				next_st.exc.vector = dbg_vec;
				next_st.flags.software_breakpoint_event = 1'b1;
			end
			exc_pkg::EX_SYS: begin
				next_st.exc.vector = gen_vec;
				next_st.flags.exception_level_flag = 1'b1;
				next_st.flags.cause_code = exc_pkg::CAUSE_SYS;
			end
			exc_pkg::EX_BP: begin
				next_st.exc.vector = gen_vec;
				next_st.flags.exception_level_flag = 1'b1;
				next_st.flags.cause_code = exc_pkg::CAUSE_BP;
			end
			default: begin
				next_st.exc.take = 1'b0;
			end
			endcase
		end

		// a fresh probe request is never lost to the consuming clear
		if (probe_break) begin
			next_st.ctrl.debug_break_request = 1'b1;
		end
	end

	// ==========================================================
	// registers and outputs
	always_ff @(posedge clk) begin
		if (srst) begin
			st.bus <= exc_pkg::BUS_IDLE;
			st.rdata <= '0;
			st.ctrl <= '0;
			st.exc_base <= exc_pkg::EXC_BASE_RST;
			st.flags <= exc_pkg::FLAGS_RST;
			st.irq_status <= '0;
			st.irq_mask <= '0;
			st.exc <= '0;
			st.master_clear_pin_sync <= 3'h7;
		end else begin
			st <= next_st;
		end
	end

	assign exc = st.exc;
	assign flags = st.flags;
	assign irq = |(st.irq_status & st.irq_mask);
endmodule
`default_nettype wire

/* File: core/exc_priority.sv */
// fixed-priority picker, lowest index wins
`timescale 1ns/100ps
`default_nettype none
module exc_priority #(
	parameter int N = 13,
	parameter int W = 4
) (
	input wire logic [N-1:0] req,
	output logic valid,
	output logic [W-1:0] idx
);
	if (N < 2 || N > (1 << W)) begin : g_check
		$error("exc_priority: N does not fit W");
	end

	always_comb begin
		valid = |req;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				idx = W'(i);
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/cpu_exception_prioritizer_checker.sv */
// concurrent checks on the exception prioritiser ports
`timescale 1ns/100ps
`default_nettype none
module cpu_exception_prioritizer_checker #(
	parameter int IBRK_N = 4,
	parameter int DBRK_N = 2
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic master_clear_pin_n,
	input wire logic probe_break,
	input wire exc_pkg::exc_src_t src,
	input wire exc_pkg::exc_out_t exc,
	input wire exc_pkg::proc_flags_t flags,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// ==========================================================
	// shared shapes
	property p_gen(k, c);
		exc.take && exc.kind == k |-> flags.cause_code == c &&
			flags.exception_level_flag && exc.vector[11:0] == 12'h180;
	endproperty
	property p_dbg(k, f);
		exc.take && exc.kind == k |-> f && (exc.vector ==
			exc_pkg::VEC_DBG_PROBE || exc.vector == exc_pkg::VEC_DBG_NOPROBE);
	endproperty
	// ==========================================================
	// assertions
	a_sreset_first: assert property (
		src.soft_reset_instr |=> exc.take && exc.kind <= exc_pkg::EX_SRST)
		else $error("soft reset request not served next");
	a_soft_flags: assert property (
		exc.take && exc.kind == exc_pkg::EX_SRST |->
		exc.vector == exc_pkg::VEC_BOOT && flags[2:0] == 3'h7)
		else $error("soft reset vector or flags wrong");
	a_nmi_boot: assert property (
		exc.take && exc.kind == exc_pkg::EX_NMI |->
		exc.vector == exc_pkg::VEC_BOOT && flags.nonmaskable_flag &&
		flags.error_level_flag && flags.boot_vector_select)
		else $error("nmi vector or flags wrong");
	a_hard_boot: assert property (
		exc.take && exc.kind == exc_pkg::EX_HRST |->
		exc.vector == exc_pkg::VEC_BOOT && flags[3:0] == 4'h3)
		else $error("hard reset vector or flags wrong");
	a_step_flag: assert property (
		p_dbg(exc_pkg::EX_DSS, flags.single_step_debug))
		else $error("single step take wrong");
	a_debug_interrupt_event_flag: assert property (
		p_dbg(exc_pkg::EX_DEBUG_INTERRUPT_EVENT, flags.debug_interrupt_event))
		else $error("debug interrupt take wrong");
	a_ibrk_flag: assert property (
		p_dbg(exc_pkg::EX_DIB, flags.instruction_break_event))
		else $error("instruction break take wrong");
	a_debug_breakpoint_instruction_flag: assert property (
		p_dbg(exc_pkg::EX_DBP, flags.software_breakpoint_event))
		else $error("software breakpoint take wrong");
	a_int_cause: assert property (
		exc.take && exc.kind == exc_pkg::EX_INT |-> flags.cause_code ==
		exc_pkg::CAUSE_INT && flags[12:10] == $past(src.int_level))
		else $error("interrupt cause or level wrong");
	a_load_misalign_error_cause: assert property (
		p_gen(exc_pkg::EX_LOAD_MISALIGN_ERROR, exc_pkg::CAUSE_LOAD_MISALIGN_ERROR))
		else $error("misaligned load take wrong");
	a_ibe_cause: assert property (
		p_gen(exc_pkg::EX_IBE, exc_pkg::CAUSE_IBE))
		else $error("fetch bus error take wrong");
	a_sys_cause: assert property (
		p_gen(exc_pkg::EX_SYS, exc_pkg::CAUSE_SYS))
		else $error("system call take wrong");
	a_bp_cause: assert property (
		p_gen(exc_pkg::EX_BP, exc_pkg::CAUSE_BP))
		else $error("break take wrong");
	a_one_wait: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer not after one wait");
	c_debug_interrupt_event: cover property (exc.take && exc.kind == exc_pkg::EX_DEBUG_INTERRUPT_EVENT);
	c_int: cover property (exc.take && exc.kind == exc_pkg::EX_INT);
	c_hrst: cover property (exc.take && exc.kind == exc_pkg::EX_HRST);
endmodule
bind cpu_exception_prioritizer cpu_exception_prioritizer_checker #(
	.IBRK_N(IBRK_N), .DBRK_N(DBRK_N)) u_chk (.clk(clk), .srst(srst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.master_clear_pin_n(master_clear_pin_n), .probe_break(probe_break),
	.src(src), .exc(exc), .flags(flags), .irq(irq));
`default_nettype wire

/* File: tb/exc_src_model.sv */
// pipeline, interrupt controller and probe stand-in
`timescale 1ns/100ps
`default_nettype none
module exc_src_model #(
	parameter logic [31:0] IADDR = 32'h9D00_0100,
	parameter logic [31:0] DADDR = 32'hA000_0040
) (
	input wire logic [12:0] fire,
	input wire logic [2:0] lvl,
	output var exc_pkg::exc_src_t src,
	output logic probe_break
);
	// idle buses show the inverse, not a stale value
	always_comb begin
		src.soft_reset_instr = fire[1];
		src.single_step = fire[2];
		probe_break = fire[3];
		src.nmi = fire[4];
		src.int_req = fire[5];
		src.int_level = fire[5] ? lvl : ~lvl;
		src.fetch_valid = fire[6];
		src.fetch_addr = fire[6] ? IADDR : ~IADDR;
		src.data_valid = fire[7];
		src.data_addr = fire[7] ? DADDR : ~DADDR;
		src.load_misalign_error = fire[8];
		src.fetch_bus_error = fire[9];
		src.debug_breakpoint_instruction = fire[10];
		src.syscall_instr = fire[11];
		src.break_instr = fire[12];
	end
endmodule
`default_nettype wire

/* File: tb/tb_cpu_exception_prioritizer.sv */
// self-checking bench of the exception prioritiser
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_exception_prioritizer;
	localparam logic [31:0] IADDR = 32'h9D00_0100;
	localparam logic [31:0] DADDR = 32'hA000_0040;
	localparam int LIMIT = 20000;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic master_clear_pin_n = 1'b1;
	logic probe_break;
	logic irq;
	logic [12:0] fire = 13'h0000;
	logic [2:0] lvl = 3'h0;
	logic [31:0] base = exc_pkg::EXC_BASE_RST;
	logic [31:0] rd;
	exc_pkg::exc_src_t src;
	exc_pkg::exc_out_t exc;
	exc_pkg::proc_flags_t flags;
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	always #4 clk = ~clk;
	cpu_exception_prioritizer #(.IBRK_N(4), .DBRK_N(2)) u_dut (
		.clk(clk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.master_clear_pin_n(master_clear_pin_n), .probe_break(probe_break),
		.src(src), .exc(exc), .flags(flags), .irq(irq));
	exc_src_model #(.IADDR(IADDR), .DADDR(DADDR)) u_src (.fire(fire),
		.lvl(lvl), .src(src), .probe_break(probe_break));
	// ==========================================================
	// common tasks
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fail_count = fail_count + 1;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] be);
		@(posedge clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		avs_byteenable <= be;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// pulse sources one cycle, then wait a bounded time for the take
	task automatic fire_exp(input logic [12:0] m, input logic [3:0] k,
		input logic [31:0] v);
		int n;
		n = 0;
		@(posedge clk);
		fire <= m;
		@(posedge clk);
		fire <= 13'h0000;
		#1;
		while (exc.take !== 1'b1 && n < 6) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("take", 32'h1, exc.take);
		chk("kind", k, exc.kind);
		chk("vector", v, exc.vector);
	endtask
	task automatic quiet(input logic [12:0] m);
		@(posedge clk);
		fire <= m;
		@(posedge clk);
		fire <= 13'h0000;
		repeat (3) begin
			#1;
			chk("no take", 32'h0, exc.take);
			@(posedge clk);
		end
	endtask
	function automatic logic [31:0] vec(input int k, input logic pe);
		case (k)
			0, 1, 4: vec = exc_pkg::VEC_BOOT;
			2, 3, 6, 7, 10: vec = pe ? exc_pkg::VEC_DBG_PROBE :
				exc_pkg::VEC_DBG_NOPROBE;
			5: vec = base + exc_pkg::INT_OFFSET;
			default: vec = base + exc_pkg::GEN_OFFSET;
		endcase
	endfunction
	function automatic logic [12:0] expf(input int k);
		case (k)
			1: expf = 13'h0007;
			2: expf = 13'h0020;
			3: expf = 13'h0040;
			4: expf = 13'h000B;
			6: expf = 13'h0080;
			7: expf = 13'h0200;
			10: expf = 13'h0100;
			default: expf = 13'h0010;
		endcase
	endfunction
	function automatic logic [4:0] cz(input int k);
		case (k)
			8: cz = exc_pkg::CAUSE_LOAD_MISALIGN_ERROR;
			9: cz = exc_pkg::CAUSE_IBE;
			11: cz = exc_pkg::CAUSE_SYS;
			default: cz = exc_pkg::CAUSE_BP;
		endcase
	endfunction
	// ==========================================================
	// scenarios
	task automatic t_reset();
		int i;
		chk("flags", exc_pkg::FLAGS_RST, flags);
		chk("irq", 32'h0, irq);
		bus(1'b0, exc_pkg::OFF_BASE, 32'h0, 4'hF);
		chk("base", exc_pkg::EXC_BASE_RST, rd);
		bus(1'b0, 8'h40, 32'h0, 4'hF);
		chk("unmapped", 32'h0, rd);
		bus(1'b1, exc_pkg::OFF_BASE, 32'h9D00_1234, 4'hF);
		bus(1'b0, exc_pkg::OFF_BASE, 32'h0, 4'hF);
		base = 32'h9D00_1000;
		chk("base", base, rd);
		for (i = 0; i < 4; i++) begin
			bus(1'b1, 8'h20 + 8'(4 * i), (IADDR + 32'(16 * i)) | 32'h1, 4'hF);
			bus(1'b0, 8'h20 + 8'(4 * i), 32'h0, 4'hF);
			chk("ibrk", (IADDR + 32'(16 * i)) | 32'h1, rd);
		end
		bus(1'b1, 8'h38, DADDR | 32'h1, 4'hF);
		bus(1'b0, 8'h38, 32'h0, 4'hF);
		chk("dbrk unused", 32'h0, rd);
		bus(1'b1, 8'h30, DADDR | 32'h1, 4'hF);
		bus(1'b0, 8'h30, 32'h0, 4'hF);
		chk("dbrk", DADDR | 32'h1, rd);
	endtask
	task automatic t_single();
		int k;
		int p;
		for (p = 0; p < 2; p++) begin
			bus(1'b1, exc_pkg::OFF_CTRL, 32'(p), 4'hF);
			for (k = 1; k < 13; k++) begin
				if (k == 5) continue;
				bus(1'b1, exc_pkg::OFF_FLAGS, 32'h0000_03FF, 4'h3);
				fire_exp(13'h1 << k, k, vec(k, p[0]));
				chk("flags", expf(k), flags[12:0]);
				if (k > 7 && k != 10) chk("cause", cz(k), flags.cause_code);
			end
		end
	endtask
	task automatic t_prio();
		int k;
		bus(1'b1, exc_pkg::OFF_CTRL, 32'h0, 4'hF);
		for (k = 1; k < 13; k++) begin
			if (k == 3 || k == 5) continue;
			fire_exp(~((13'h1 << k) - 13'h1) & 13'h1FD6, k, vec(k, 1'b0));
		end
		bus(1'b1, exc_pkg::OFF_CTRL, 32'h1, 4'hF);
		@(posedge clk);
		fire <= 13'h0008;
		@(posedge clk);
		fire <= 13'h0010;
		@(posedge clk);
		fire <= 13'h0000;
		#1;
		chk("debug_interrupt_event take", 32'h1, exc.take);
		chk("debug_interrupt_event kind", exc_pkg::EX_DEBUG_INTERRUPT_EVENT, exc.kind);
		quiet(13'h0000);
	endtask
	task automatic t_int();
		bus(1'b1, exc_pkg::OFF_CTRL, 32'h4, 4'hF);
		bus(1'b1, exc_pkg::OFF_FLAGS, 32'h0000_03FF, 4'h3);
		lvl <= 3'h3;
		fire_exp(13'h0060, exc_pkg::EX_INT, vec(5, 1'b0));
		chk("cause", exc_pkg::CAUSE_INT, flags.cause_code);
		chk("level", 32'h3, flags.interrupt_priority_level);
		lvl <= 3'h2;
		quiet(13'h0020);
		bus(1'b1, exc_pkg::OFF_CTRL, 32'h0, 4'hF);
		bus(1'b1, exc_pkg::OFF_FLAGS, 32'h0000_03FF, 4'h3);
		quiet(13'h0020);
	endtask
	task automatic t_irq();
		bus(1'b1, exc_pkg::OFF_IRQ_MASK, 32'h0000_0800, 4'hF);
		bus(1'b1, exc_pkg::OFF_IRQ_STATUS, 32'h0000_1FFF, 4'hF);
		fire_exp(13'h0800, exc_pkg::EX_SYS, vec(11, 1'b0));
		chk("irq set", 32'h1, irq);
		bus(1'b0, exc_pkg::OFF_IRQ_STATUS, 32'h0, 4'hF);
		chk("status", 32'h0000_0800, rd);
		bus(1'b1, exc_pkg::OFF_IRQ_STATUS, 32'h0000_0800, 4'hF);
		#1;
		chk("irq clear", 32'h0, irq);
		bus(1'b1, exc_pkg::OFF_IRQ_MASK, 32'h0, 4'hF);
		fire_exp(13'h0800, exc_pkg::EX_SYS, vec(11, 1'b0));
		chk("irq masked", 32'h0, irq);
	endtask
	task automatic t_hrst();
		int n;
		n = 0;
		fire_exp(13'h0002, exc_pkg::EX_SRST, vec(1, 1'b0));
		@(posedge clk);
		master_clear_pin_n <= 1'b0;
		#1;
		while (exc.take !== 1'b1 && n < 8) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("hard kind", exc_pkg::EX_HRST, exc.kind);
		chk("hard vector", exc_pkg::VEC_BOOT, exc.vector);
		chk("hard flags", 32'h3, flags[3:0]);
		@(posedge clk);
		master_clear_pin_n <= 1'b1;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		t_reset();
		t_single();
		t_prio();
		t_int();
		t_irq();
		t_hrst();
		wrap_up();
	end
endmodule
`default_nettype wire
